//--- icfg_pkg.sv
// Constants, types and lookup functions for the configuration access block.
// Assumes both ends run on one 10 MHz clock with a synchronous reset.
package icfg_pkg;
   // Bus and storage sizes
   localparam int ADDR_W = 12; // I/O address width
   localparam int CFG_NUM = 8; // Shared configuration registers
   // Fixed plug and play port addresses
   localparam logic [11:0] PNP_SEL_ADDR = 12'h279;
   localparam logic [11:0] PNP_WR_ADDR = 12'ha79;
   // Read port placement: low bits forced, top bit of stored byte required
   localparam logic [1:0] RDPORT_LOW = 2'h3;
   localparam int RDPORT_MSB = 7; // Keeps the port within 0x203..0x3ff
   // Plug and play register numbers
   localparam logic [7:0] PNP_RDPORT_SEL = 8'h00; // Sets read port address
   localparam logic [4:0] PNP_CFG_GRP = 5'h01; // Numbers 0x08..0x0f reach cfg
   // Index port signature after reset
   localparam logic [7:0] SIG_FIRST = 8'h88;
   localparam logic [7:0] SIG_SECOND = 8'hdf;
   localparam logic [1:0] SIG_DONE = 2'h2;
   // Configuration register indices and fields
   localparam logic [2:0] CFG_IRCTL = 3'h0; // Bit 0 enables the fast window
   localparam int IR_EN_BIT = 0;
   localparam logic [2:0] CFG_FIR_LO = 3'h1;
   localparam logic [2:0] CFG_FIR_HI = 3'h2;
   localparam logic [2:0] CFG_SIR_LO = 3'h3;
   localparam logic [2:0] CFG_SIR_HI = 3'h4;
   localparam int FIR_WIN_W = 3; // Fast window spans eight ports
   // Host controller register offsets
   localparam logic [2:0] H_ADDR = 3'h0;
   localparam logic [2:0] H_WDATA = 3'h1;
   localparam logic [2:0] H_CMD = 3'h2;
   localparam logic [2:0] H_STAT = 3'h3;
   localparam logic [2:0] H_RDATA = 3'h4;
   localparam logic [2:0] H_IDXPORT = 3'h5;
   localparam logic [2:0] H_RDPORT = 3'h6;
   // Reset values of host registers
   localparam logic [11:0] H_IDXPORT_RST = 12'h398;
   localparam logic [11:0] H_RDPORT_RST = 12'h203;

   // Access method chosen by the straps
   typedef enum logic [1:0] {ICFG_PNP, ICFG_IND, ICFG_DIR} icfg_method_t;
   // Host operations, taken from the command register
   typedef enum logic [2:0] {
      OP_IOWR, OP_IORD, OP_DIRWR, OP_DIRRD, OP_INDWR, OP_INDRD, OP_PNPWR, OP_PNPRD
   } icfg_op_t;
   // One host bus cycle
   typedef struct packed {
      logic wr;
      logic [11:0] addr;
      logic [7:0] data;
      logic direct;
      logic last;
   } icfg_step_t;

   // Method strap decode; unused codes fall back to plug and play
   function automatic icfg_method_t method_of(input logic [2:0] s);
      case (s)
         3'h1: method_of = ICFG_IND;
         3'h2: method_of = ICFG_DIR;
         default: method_of = ICFG_PNP;
      endcase
   endfunction : method_of

   // Index port address from the base straps; data port is the next one
   function automatic logic [11:0] idx_port(input logic [1:0] b);
      case (b)
         2'h0: idx_port = 12'h398;
         2'h1: idx_port = 12'h26e;
         2'h2: idx_port = 12'h15c;
         default: idx_port = 12'h02e;
      endcase
   endfunction : idx_port

   // Default register image per profile
   function automatic logic [7:0] cfg_default(input logic [2:0] p, input logic [2:0] i);
      logic [11:0] fir;
      fir = {4'h3, p, 5'h00}; // Fast base steps by 0x20 per profile
      case (i)
         CFG_IRCTL: cfg_default = {7'h00, (p != 3'h0)};
         CFG_FIR_LO: cfg_default = fir[7:0];
         CFG_FIR_HI: cfg_default = {4'h0, fir[11:8]};
         CFG_SIR_LO: cfg_default = 8'hf8;
         CFG_SIR_HI: cfg_default = 8'h03;
         default: cfg_default = 8'h00;
      endcase
   endfunction : cfg_default
endpackage : icfg_pkg

//--- icfg_if.sv
// ISA-style I/O carrier joining the host end and the device end.
// Assumes both ends share clk; strobes are one cycle wide.
interface icfg_if (
   input wire logic clk
);
   logic [11:0] io_addr; // I/O address
   logic [7:0] io_wdata; // Write data
   logic io_wr; // Write strobe
   logic io_rd; // Read strobe
   logic dcfg_n; // Direct configuration strobe, active low
   logic [7:0] io_rdata; // Read data, cycle after the strobe
   logic io_rvalid; // Device answered the read

   modport dev (
      input clk, io_addr, io_wdata, io_wr, io_rd, dcfg_n,
      output io_rdata, io_rvalid
   );
   modport host (
      input clk, io_rdata, io_rvalid,
      output io_addr, io_wdata, io_wr, io_rd, dcfg_n
   );
endinterface : icfg_if

//--- icfg_sync.sv
// Two-stage synchroniser for strap pins.
// Assumes the inputs are quasi-static levels.
module icfg_sync #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q; // First stage, read only by second

   // Two flops, no reset needed
   always_ff @(posedge clk) begin
      meta_q <= d;
      q <= meta_q;
   end
endmodule : icfg_sync

//--- icfg_device.sv
// Device end: configuration register access over three strap-chosen methods.
// Assumes the host drives icfg_if on clk; straps are asynchronous pins.
//
// Added by the designer: the address-and-strobe port.
module icfg_device (
   input wire logic clk,
   input wire logic srst,
   icfg_if.dev bus,
   input wire logic cfg_method_strap_2,
   input wire logic cfg_method_strap_1,
   input wire logic cfg_method_strap_0,
   input wire logic port_base_strap_1,
   input wire logic port_base_strap_0,
   input wire logic [2:0] default_profile_straps,
   output icfg_pkg::icfg_method_t method,
   output logic ir_enable,
   output logic [11:0] fir_base,
   output logic [11:0] sir_base,
   output logic fir_cs,
   output logic fir_we,
   output logic [2:0] fir_offset
);
   logic [7:0] strap_s; // Synchronised straps
   icfg_pkg::icfg_method_t method_q; // Latched method
   icfg_pkg::icfg_method_t strap_method; // Method seen on straps now
   logic [1:0] base_q; // Latched base straps
   logic [7:0] cfg_q [icfg_pkg::CFG_NUM]; // Shared configuration storage
   logic [7:0] index_q; // Indirect index
   logic arm_q; // First data write seen
   logic [7:0] arm_data_q; // Value of first data write
   logic [1:0] sig_q; // Signature read count
   logic [7:0] pnp_sel_q; // Plug and play register number
   logic [7:0] rdport_q; // Read port address bits 9:2
   logic rdport_en_q; // Read port placed
   logic [7:0] rdata_q; // Read answer
   logic rvalid_q; // Read answered
   logic fir_cs_q, fir_we_q; // Fast window strobes
   logic [2:0] fir_off_q; // Fast window offset
   logic [2:0] load_prof; // Profile used at reset
   logic [11:0] idx_addr; // Index port address
   logic acc; // Any bus access
   logic dir_hit, idx_hit, dat_hit; // Port decodes
   logic pnp_sel_wr, pnp_dat_wr, pnp_rd; // Plug and play decodes
   logic pnp_cfg; // Selected number reaches cfg
   logic ind_ok; // Index reaches cfg
   logic cfg_we; // Storage write enable
   logic [2:0] cfg_widx; // Storage write index
   logic fir_hit; // Fast window decode
   logic [7:0] rdata_d; // Read answer next
   logic rvalid_d; // Answer next

   // Strap pins through two flops
   icfg_sync #(.W(8)) icfg_sync_i (
      .clk(clk),
      .d({cfg_method_strap_2, cfg_method_strap_1, cfg_method_strap_0,
          port_base_strap_1, port_base_strap_0, default_profile_straps}),
      .q(strap_s)
   );

   // Profile applies only when straps ask for indirect
   assign strap_method = icfg_pkg::method_of(strap_s[7:5]);
   assign load_prof = (strap_method == icfg_pkg::ICFG_IND) ? strap_s[2:0] : 3'h0;

   // Straps caught while reset is held
   always_ff @(posedge clk) begin
      if (srst) begin
         method_q <= strap_method;
         base_q <= strap_s[4:3];
      end
   end

   // Address decode
   assign acc = bus.io_wr | bus.io_rd;
   assign idx_addr = icfg_pkg::idx_port(base_q);
   assign dir_hit = (method_q == icfg_pkg::ICFG_DIR) && !bus.dcfg_n && acc;
   assign idx_hit = (method_q == icfg_pkg::ICFG_IND) && acc && (bus.io_addr == idx_addr);
   assign dat_hit = (method_q == icfg_pkg::ICFG_IND) && acc
      && (bus.io_addr == (idx_addr | 12'h001));
   // Only writes decode at the select address
   assign pnp_sel_wr = (method_q == icfg_pkg::ICFG_PNP) && bus.io_wr
      && (bus.io_addr == icfg_pkg::PNP_SEL_ADDR);
   assign pnp_dat_wr = (method_q == icfg_pkg::ICFG_PNP) && bus.io_wr
      && (bus.io_addr == icfg_pkg::PNP_WR_ADDR);
   assign pnp_rd = (method_q == icfg_pkg::ICFG_PNP) && bus.io_rd && rdport_en_q
      && (bus.io_addr == {2'h0, rdport_q, icfg_pkg::RDPORT_LOW});
   assign pnp_cfg = (pnp_sel_q[7:3] == icfg_pkg::PNP_CFG_GRP);
   assign ind_ok = (index_q[7:3] == 5'h00);

   // One write path into the shared storage
   always_comb begin
      cfg_we = 1'b0;
      cfg_widx = 3'h0;
      if (dir_hit && bus.io_wr) begin
         cfg_we = 1'b1;
         cfg_widx = bus.io_addr[2:0];
      end else if (dat_hit && bus.io_wr && arm_q && (bus.io_wdata == arm_data_q)) begin
         cfg_we = ind_ok;
         cfg_widx = index_q[2:0];
      end else if (pnp_dat_wr && pnp_cfg) begin
         cfg_we = 1'b1;
         cfg_widx = pnp_sel_q[2:0];
      end
   end

   // Storage, loaded from the profile during reset
   always_ff @(posedge clk) begin
      for (int i = 0; i < icfg_pkg::CFG_NUM; i++) begin
         if (srst) begin
            cfg_q[i] <= icfg_pkg::cfg_default(load_prof, 3'(i));
         end else if (cfg_we && (cfg_widx == 3'(i))) begin
            cfg_q[i] <= bus.io_wdata;
         end
      end
   end

   // Indirect index register
   always_ff @(posedge clk) begin
      if (srst) begin
         index_q <= 8'h00;
      end else if (idx_hit && bus.io_wr) begin
         index_q <= bus.io_wdata;
      end
   end

   // Double-write guard
   always_ff @(posedge clk) begin
      if (srst) begin
         arm_q <= 1'b0;
         arm_data_q <= 8'h00;
      end else if (dat_hit && bus.io_wr) begin
         // Matching second write commits and disarms; else rearm
         arm_q <= !(arm_q && (bus.io_wdata == arm_data_q));
         arm_data_q <= bus.io_wdata;
      end else if (acc) begin
         arm_q <= 1'b0;
      end
   end

   // Signature count on index reads
   always_ff @(posedge clk) begin
      if (srst) begin
         sig_q <= 2'h0;
      end else if (idx_hit && bus.io_wr) begin
         sig_q <= icfg_pkg::SIG_DONE; // Real index replaces signature
      end else if (idx_hit && bus.io_rd && (sig_q != icfg_pkg::SIG_DONE)) begin
         sig_q <= sig_q + 2'h1;
      end
   end

   // Plug and play select and read port
   always_ff @(posedge clk) begin
      if (srst) begin
         pnp_sel_q <= 8'h00;
         rdport_q <= 8'h00;
         rdport_en_q <= 1'b0;
      end else if (pnp_sel_wr) begin
         pnp_sel_q <= bus.io_wdata;
      end else if (pnp_dat_wr && (pnp_sel_q == icfg_pkg::PNP_RDPORT_SEL)) begin
         rdport_q <= bus.io_wdata;
         rdport_en_q <= bus.io_wdata[icfg_pkg::RDPORT_MSB];
      end
   end

   // Read answer select; unmatched reads get none
   always_comb begin
      rvalid_d = 1'b1;
      rdata_d = 8'h00;
      if (dir_hit && bus.io_rd) begin
         rdata_d = cfg_q[bus.io_addr[2:0]];
      end else if (idx_hit && bus.io_rd) begin
         case (sig_q)
            2'h0: rdata_d = icfg_pkg::SIG_FIRST;
            2'h1: rdata_d = icfg_pkg::SIG_SECOND;
            default: rdata_d = index_q;
         endcase
      end else if (dat_hit && bus.io_rd) begin
         rdata_d = ind_ok ? cfg_q[index_q[2:0]] : 8'h00;
      end else if (pnp_rd) begin
         if (pnp_sel_q == icfg_pkg::PNP_RDPORT_SEL) begin
            rdata_d = rdport_q;
         end else if (pnp_cfg) begin
            rdata_d = cfg_q[pnp_sel_q[2:0]];
         end
      end else begin
         rvalid_d = 1'b0;
      end
   end

   // Read answer register
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // Fast window decode, gated by enable bit
   assign fir_hit = acc && cfg_q[icfg_pkg::CFG_IRCTL][icfg_pkg::IR_EN_BIT]
      && ({cfg_q[icfg_pkg::CFG_FIR_HI][3:0], cfg_q[icfg_pkg::CFG_FIR_LO][7:3]}
         == bus.io_addr[11:icfg_pkg::FIR_WIN_W])
      && !dir_hit && !idx_hit && !dat_hit;

   // Fast window strobes
   always_ff @(posedge clk) begin
      if (srst) begin
         fir_cs_q <= 1'b0;
         fir_we_q <= 1'b0;
         fir_off_q <= 3'h0;
      end else begin
         fir_cs_q <= fir_hit;
         fir_we_q <= fir_hit && bus.io_wr;
         fir_off_q <= bus.io_addr[2:0];
      end
   end

   // Outputs straight from flops
   assign bus.io_rdata = rdata_q;
   assign bus.io_rvalid = rvalid_q;
   assign method = method_q;
   assign ir_enable = cfg_q[icfg_pkg::CFG_IRCTL][icfg_pkg::IR_EN_BIT];
   assign fir_base = {cfg_q[icfg_pkg::CFG_FIR_HI][3:0], cfg_q[icfg_pkg::CFG_FIR_LO]};
   assign sir_base = {cfg_q[icfg_pkg::CFG_SIR_HI][3:0], cfg_q[icfg_pkg::CFG_SIR_LO]};
   assign fir_cs = fir_cs_q;
   assign fir_we = fir_we_q;
   assign fir_offset = fir_off_q;
endmodule : icfg_device

//--- icfg_host.sv
// Host end: runs configuration sequences on icfg_if from register commands.
// Assumes software uses the plain register port on the same clock.
module icfg_host (
   input wire logic clk,
   input wire logic srst,
   icfg_if.host bus,
   input wire logic [2:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata
);
   typedef enum logic [1:0] {HS_IDLE, HS_STEP, HS_GAP, HS_RSP} icfg_hstate_t;
   icfg_hstate_t state_q; // Sequencer state
   icfg_pkg::icfg_op_t op_q; // Running operation
   logic [1:0] step_q; // Step within operation
   logic [11:0] addr_q; // Address or register number
   logic [7:0] wdata_q; // Data to write
   logic [11:0] idxport_q; // Index port address in use
   logic [11:0] rdport_q; // Read port address in use
   logic [7:0] rdata_q; // Last read result
   logic noans_q; // Last read got no answer
   logic [15:0] reg_rdata_q; // Register read data
   logic [11:0] io_addr_q; // Bus address
   logic [7:0] io_wdata_q; // Bus write data
   logic io_wr_q, io_rd_q, dcfg_n_q; // Bus strobes
   icfg_pkg::icfg_step_t cur; // Current step

   // Bus cycle for each step of each operation
   function automatic icfg_pkg::icfg_step_t step_of(input icfg_pkg::icfg_op_t op,
      input logic [1:0] s, input logic [11:0] a, input logic [7:0] d,
      input logic [11:0] ip, input logic [11:0] rp);
      icfg_pkg::icfg_step_t r;
      r = '{wr: 1'b1, addr: a, data: d, direct: 1'b0, last: 1'b1};
      case (op)
         icfg_pkg::OP_IORD: r.wr = 1'b0;
         icfg_pkg::OP_DIRWR: r.direct = 1'b1;
         icfg_pkg::OP_DIRRD: r = '{wr: 1'b0, addr: a, data: d, direct: 1'b1, last: 1'b1};
         icfg_pkg::OP_INDWR, icfg_pkg::OP_INDRD: begin
            // Index first, then data port
            r.addr = (s == 2'h0) ? ip : (ip | 12'h001);
            r.data = (s == 2'h0) ? a[7:0] : d;
            r.wr = (s == 2'h0) || (op == icfg_pkg::OP_INDWR);
            // Same value written twice for a write
            r.last = (op == icfg_pkg::OP_INDWR) ? (s == 2'h2) : (s == 2'h1);
         end
         icfg_pkg::OP_PNPWR, icfg_pkg::OP_PNPRD: begin
            // Register number always goes out first
            r.addr = (s != 2'h0) ? ((op == icfg_pkg::OP_PNPWR) ? icfg_pkg::PNP_WR_ADDR : rp)
               : icfg_pkg::PNP_SEL_ADDR;
            r.data = (s == 2'h0) ? a[7:0] : d;
            r.wr = (s == 2'h0) || (op == icfg_pkg::OP_PNPWR);
            r.last = (s == 2'h1);
         end
         default: r = r;
      endcase
      step_of = r;
   endfunction : step_of

   assign cur = step_of(op_q, step_q, addr_q, wdata_q, idxport_q, rdport_q);

   // Software registers
   always_ff @(posedge clk) begin
      if (srst) begin
         addr_q <= 12'h000;
         wdata_q <= 8'h00;
         idxport_q <= icfg_pkg::H_IDXPORT_RST;
         rdport_q <= icfg_pkg::H_RDPORT_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            icfg_pkg::H_ADDR: addr_q <= reg_wdata[11:0];
            icfg_pkg::H_WDATA: wdata_q <= reg_wdata[7:0];
            icfg_pkg::H_IDXPORT: idxport_q <= reg_wdata[11:0];
            // Read port always ends in binary 11
            icfg_pkg::H_RDPORT: rdport_q <= {reg_wdata[11:2], icfg_pkg::RDPORT_LOW};
            default: addr_q <= addr_q;
         endcase
      end
   end

   // Sequencer; a command while busy is ignored
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= HS_IDLE;
         op_q <= icfg_pkg::OP_IOWR;
         step_q <= 2'h0;
      end else begin
         case (state_q)
            HS_IDLE: if (reg_wr && reg_addr == icfg_pkg::H_CMD) begin
               op_q <= icfg_pkg::icfg_op_t'(reg_wdata[2:0]);
               step_q <= 2'h0;
               state_q <= HS_STEP;
            end
            HS_STEP: begin
               step_q <= step_q + 2'h1;
               if (cur.last) begin
                  state_q <= cur.wr ? HS_IDLE : HS_GAP;
               end
            end
            HS_GAP: state_q <= HS_RSP; // Strobe on the bus
            HS_RSP: state_q <= HS_IDLE; // Answer on the bus
            default: state_q <= HS_IDLE;
         endcase
      end
   end

   // Bus drive, one strobe per step
   always_ff @(posedge clk) begin
      if (srst) begin
         io_addr_q <= 12'h000;
         io_wdata_q <= 8'h00;
         io_wr_q <= 1'b0;
         io_rd_q <= 1'b0;
         dcfg_n_q <= 1'b1;
      end else begin
         io_wr_q <= (state_q == HS_STEP) && cur.wr;
         io_rd_q <= (state_q == HS_STEP) && !cur.wr;
         dcfg_n_q <= !((state_q == HS_STEP) && cur.direct);
         if (state_q == HS_STEP) begin
            io_addr_q <= cur.addr;
            io_wdata_q <= cur.data;
         end
      end
   end

   // Read result capture
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_q <= 8'h00;
         noans_q <= 1'b0;
      end else if (state_q == HS_RSP) begin
         rdata_q <= bus.io_rdata;
         noans_q <= !bus.io_rvalid;
      end
   end

   // Register read, data one cycle later
   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata_q <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            icfg_pkg::H_ADDR: reg_rdata_q <= {4'h0, addr_q};
            icfg_pkg::H_WDATA: reg_rdata_q <= {8'h00, wdata_q};
            icfg_pkg::H_STAT: reg_rdata_q <= {14'h0000, noans_q, state_q != HS_IDLE};
            icfg_pkg::H_RDATA: reg_rdata_q <= {8'h00, rdata_q};
            icfg_pkg::H_IDXPORT: reg_rdata_q <= {4'h0, idxport_q};
            icfg_pkg::H_RDPORT: reg_rdata_q <= {4'h0, rdport_q};
            default: reg_rdata_q <= 16'h0000;
         endcase
      end else begin
         reg_rdata_q <= 16'h0000;
      end
   end

   assign reg_rdata = reg_rdata_q;
   assign bus.io_addr = io_addr_q;
   assign bus.io_wdata = io_wdata_q;
   assign bus.io_wr = io_wr_q;
   assign bus.io_rd = io_rd_q;
   assign bus.dcfg_n = dcfg_n_q;
endmodule : icfg_host

//--- icfg_properties.sv
// Carrier checks between the host end and the device end.
// Assumes the index pair sits at 0x398 whenever that port is read.
module icfg_properties (
   input wire logic clk,
   input wire logic srst,
   input wire logic [11:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic dcfg_n,
   input wire logic [7:0] io_rdata,
   input wire logic io_rvalid,
   input wire icfg_pkg::icfg_method_t method
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] sig_q; // Index reads since reset
   logic ind_rd; // Index read in indirect method
   assign ind_rd = io_rd && io_addr == 12'h398 && method == icfg_pkg::ICFG_IND;
   // Signature step counter, stopped by an index write
   always_ff @(posedge clk) begin
      if (srst) begin
         sig_q <= 2'h0;
      end else if (io_wr && io_addr == 12'h398) begin
         sig_q <= 2'h3;
      end else if (ind_rd && sig_q != 2'h3) begin
         sig_q <= sig_q + 2'h1;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   sequence s_ans(logic [7:0] d); io_rvalid && io_rdata == d; endsequence
   sequence s_quiet; !io_rvalid; endsequence
   a_sig_first: assert property (ind_rd && sig_q == 2'h0 |=> s_ans(8'h88))
      else $error("first signature wrong");
   a_sig_second: assert property (ind_rd && sig_q == 2'h1 |=> s_ans(8'hdf))
      else $error("second signature wrong");
   a_sel_port_silent: assert property (io_rd && io_addr == 12'h279 |=> s_quiet)
      else $error("read of select port answered");
   a_wr_port_silent: assert property (io_rd && io_addr == 12'ha79 |=> s_quiet)
      else $error("read of write port answered");
   a_answer_cause: assert property (io_rvalid |-> $past(io_rd))
      else $error("answer without read");
   a_index_answers: assert property (ind_rd |=> io_rvalid)
      else $error("index read not answered");
   a_direct_answers: assert property (method == icfg_pkg::ICFG_DIR && io_rd && !dcfg_n
      |=> io_rvalid)
      else $error("direct read not answered");
   a_select_then_data: assert property (method == icfg_pkg::ICFG_PNP && io_wr
      && io_addr == 12'h279 |=> io_wr || io_rd)
      else $error("select not followed by data access");
endmodule : icfg_properties

//--- isa_config_register_access_tb_top.sv
// Bench: software port drives the host end, which meets the device end.
// Assumes a 100 ns clock and the host register map of the package.
module isa_config_register_access_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, srst, reg_wr, reg_rd; // Clock, reset, strobes
   logic [2:0] reg_addr, cfg_mode, cfg_profile; // Offset and straps
   logic [1:0] cfg_base; // Index pair straps
   logic [15:0] reg_wdata, reg_rdata, r; // Register data
   logic ir_enable, fir_cs, fir_we; // Fast window state
   logic [2:0] fir_offset; // Fast window offset
   logic [3:0] fir_acc; // Write flag and offset of last window access
   logic [11:0] fir_base, sir_base; // Base images
   icfg_pkg::icfg_method_t method; // Chosen method
   int err_count, samples_checked, cs_cnt, n; // Counters
   logic [11:0] ports [4] = '{12'h398, 12'h26e, 12'h15c, 12'h02e}; // Index ports
   icfg_if icfg_if_i (.clk(clk));
   icfg_host icfg_host_i (.clk(clk), .srst(srst), .bus(icfg_if_i), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   icfg_device icfg_device_i (.clk(clk), .srst(srst), .bus(icfg_if_i),
      .cfg_method_strap_2(cfg_mode[2]), .cfg_method_strap_1(cfg_mode[1]),
      .cfg_method_strap_0(cfg_mode[0]), .port_base_strap_1(cfg_base[1]),
      .port_base_strap_0(cfg_base[0]), .default_profile_straps(cfg_profile),
      .method(method), .ir_enable(ir_enable), .fir_base(fir_base), .sir_base(sir_base),
      .fir_cs(fir_cs), .fir_we(fir_we), .fir_offset(fir_offset));
   icfg_properties icfg_properties_i (.clk(clk), .srst(srst), .io_addr(icfg_if_i.io_addr),
      .io_wr(icfg_if_i.io_wr), .io_rd(icfg_if_i.io_rd), .dcfg_n(icfg_if_i.dcfg_n),
      .io_rdata(icfg_if_i.io_rdata), .io_rvalid(icfg_if_i.io_rvalid), .method(method));
   // Free running clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Count fast window selects
   always @(posedge clk) begin
      if (fir_cs === 1'b1) begin
         cs_cnt++;
         fir_acc = {fir_we, fir_offset};
      end
   end
   // Compare one value
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // One register write
   task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr_reg
   // One register read, data taken the cycle after
   task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd_reg
   // Start a host operation and wait until idle
   task automatic run(input logic [2:0] op, input logic [11:0] a, input logic [7:0] d);
      logic [15:0] s;
      wr_reg(icfg_pkg::H_ADDR, {4'h0, a});
      wr_reg(icfg_pkg::H_WDATA, {8'h00, d});
      wr_reg(icfg_pkg::H_CMD, {13'h0000, op});
      s = 16'h0001;
      for (int i = 0; i < 20 && s[0] !== 1'b0; i++) begin
         rd_reg(icfg_pkg::H_STAT, s);
      end
      // Host still busy after the poll limit counts as a mismatch
      if (s[0] !== 1'b0) begin
         err_count++;
         $display("wrong value at %0t: host stays busy", $time);
      end
      rd_reg(icfg_pkg::H_RDATA, r);
   endtask : run
   // New straps, then reset long enough for the synchronisers
   task automatic restart(input logic [2:0] m, input logic [1:0] b);
      @(posedge clk);
      cfg_mode <= m;
      cfg_base <= b;
      srst <= 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
   endtask : restart
   // Verdict and end of run
   task automatic stop_test();
      $display("checked %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test
   // Main sequence
   initial begin
      srst = 1'b1;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      cfg_mode = 3'h1;
      cfg_base = 2'h0;
      cfg_profile = 3'h2;
      restart(3'h1, 2'h0);
      check({14'h0000, method}, 16'h0001);
      run(icfg_pkg::OP_IORD, 12'h398, 8'h00);
      check(r, 16'h0088);
      run(icfg_pkg::OP_IORD, 12'h398, 8'h00);
      check(r, 16'h00df);
      check({4'h0, fir_base}, 16'h0300 + 16'h0020 * cfg_profile);
      check({15'h0000, ir_enable}, 16'h0001);
      run(icfg_pkg::OP_IOWR, 12'h398, 8'h03);
      run(icfg_pkg::OP_IOWR, 12'h399, 8'h66);
      run(icfg_pkg::OP_IORD, 12'h2e0, 8'h00);
      run(icfg_pkg::OP_IOWR, 12'h399, 8'h66);
      run(icfg_pkg::OP_INDRD, 12'h003, 8'h00);
      check(r, 16'h00f8);
      run(icfg_pkg::OP_IOWR, 12'h399, 8'h55);
      run(icfg_pkg::OP_IOWR, 12'h399, 8'h55);
      check({4'h0, sir_base}, 16'h0355);
      run(icfg_pkg::OP_INDWR, 12'h001, 8'h20);
      check({4'h0, fir_base}, 16'h0320);
      n = cs_cnt;
      run(icfg_pkg::OP_IOWR, 12'h321, 8'h00);
      check(16'(cs_cnt - n), 16'h0001);
      check({12'h000, fir_acc}, 16'h0009);
      restart(3'h2, 2'h0);
      check({4'h0, fir_base}, 16'h0300);
      run(icfg_pkg::OP_DIRWR, 12'h003, 8'h77);
      run(icfg_pkg::OP_DIRRD, 12'h003, 8'h00);
      check(r, 16'h0077);
      check({4'h0, sir_base}, 16'h0377);
      restart(3'h0, 2'h0);
      check({14'h0000, method}, 16'h0000);
      run(icfg_pkg::OP_PNPWR, 12'h000, 8'h80);
      run(icfg_pkg::OP_PNPWR, 12'h00b, 8'h5a);
      run(icfg_pkg::OP_PNPRD, 12'h00b, 8'h00);
      check(r, 16'h005a);
      run(icfg_pkg::OP_IORD, 12'h279, 8'h00);
      rd_reg(icfg_pkg::H_STAT, r);
      check(r, 16'h0002);
      run(icfg_pkg::OP_IORD, 12'ha79, 8'h00);
      rd_reg(icfg_pkg::H_STAT, r);
      check(r, 16'h0002);
      wr_reg(icfg_pkg::H_RDPORT, 16'h0200);
      rd_reg(icfg_pkg::H_RDPORT, r);
      check(r, 16'h0203);
      n = cs_cnt;
      run(icfg_pkg::OP_IOWR, 12'h300, 8'h00);
      run(icfg_pkg::OP_PNPWR, 12'h008, 8'h01);
      run(icfg_pkg::OP_IOWR, 12'h301, 8'h00);
      check(16'(cs_cnt - n), 16'h0001);
      for (int i = 1; i < 4; i++) begin
         restart(3'h1, i[1:0]);
         run(icfg_pkg::OP_IORD, ports[i], 8'h00);
         check(r, 16'h0088);
      end
      stop_test();
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      stop_test();
   end
endmodule : isa_config_register_access_tb_top
